// *** verilog/remote_freq_pkg.sv ***
`default_nettype none
package remote_freq_pkg;
	// ==========================================================
	// Timing
	localparam int unsigned CLK_HZ = 10_000_000;
	localparam int unsigned CLK_NS = 100;
	localparam int unsigned MINUTE_S = 60;
	localparam int unsigned MINUTE_CYC = MINUTE_S * CLK_HZ;
	localparam int unsigned TENTH_S_NS = 100_000_000;
	localparam int unsigned CYC_PER_TENTH = TENTH_S_NS / CLK_NS;
	// Frequencies in 0.01 Hz, times in 0.1 s
	localparam logic [15:0] RAMP_REF_FREQ = 16'h1388;
	localparam logic [15:0] DECEL_FOLLOWS = 16'h270f;
	// ==========================================================
	// Register byte addresses
	localparam logic [7:0] ADDR_REMOTE_SEL = 8'h00;
	localparam logic [7:0] ADDR_INCH_FREQ = 8'h04;
	localparam logic [7:0] ADDR_INCH_RAMP = 8'h08;
	localparam logic [7:0] ADDR_OP_MODE = 8'h0c;
	localparam logic [7:0] ADDR_PATTERN = 8'h10;
	localparam logic [7:0] ADDR_BASE_FREQ = 8'h14;
	localparam logic [7:0] ADDR_MAX_FREQ = 8'h18;
	localparam logic [7:0] ADDR_PRIM_ACC = 8'h1c;
	localparam logic [7:0] ADDR_PRIM_DEC = 8'h20;
	localparam logic [7:0] ADDR_SEC_RAMP = 8'h24;
	localparam logic [7:0] ADDR_SEC_DEC = 8'h28;
	localparam logic [7:0] ADDR_SPEED_HIGH = 8'h2c;
	localparam logic [7:0] ADDR_SPEED_MID = 8'h30;
	localparam logic [7:0] ADDR_SPEED_LOW = 8'h34;
	localparam logic [7:0] ADDR_CONTROL = 8'h38;
	localparam logic [7:0] ADDR_SET_FREQ = 8'h3c;
	localparam logic [7:0] ADDR_STORED = 8'h40;
	localparam logic [7:0] ADDR_STATUS = 8'h44;
	// ==========================================================
	// Reset values
	localparam logic [1:0] RST_REMOTE_SEL = 2'h0;
	localparam logic [15:0] RST_INCH_FREQ = 16'h01f4;
	localparam logic [15:0] RST_INCH_RAMP = 16'h0005;
	localparam logic [2:0] RST_OP_MODE = 3'h0;
	localparam logic [1:0] RST_PATTERN = 2'h0;
	localparam logic [15:0] RST_BASE_FREQ = 16'h1388;
	localparam logic [15:0] RST_MAX_FREQ = 16'h2ee0;
	localparam logic [15:0] RST_PRIM_TIME = 16'h0032;
	localparam logic [15:0] RST_SEC_RAMP = 16'h0032;
	localparam logic [15:0] RST_SEC_DEC = 16'h270f;
	localparam logic [15:0] RST_SPEED_HIGH = 16'h1388;
	localparam logic [15:0] RST_SPEED_MID = 16'h0bb8;
	localparam logic [15:0] RST_SPEED_LOW = 16'h03e8;
	// ==========================================================
	// Field positions and codes
	localparam int unsigned CTRL_PANEL_JOG_BIT = 0;
	localparam int unsigned STAT_JOG_BIT = 0;
	localparam int unsigned STAT_RUN_BIT = 1;
	localparam int unsigned STAT_REMOTE_BIT = 2;
	localparam logic [1:0] SEL_STORE = 2'h1;
	localparam logic [1:0] SEL_CLEAR_ON_STOP = 2'h3;
	localparam logic [2:0] OP_EXT_JOG_ONLY = 3'h3;
	localparam logic [2:0] OP_PANEL_START = 3'h4;
	localparam logic [1:0] PATTERN_S_A = 2'h1;

	typedef struct packed {
		logic increase;
		logic decrease;
		logic clear;
		logic fwd_start;
		logic rev_start;
		logic second_fn;
		logic jog_select;
		logic run_key;
		logic fwd_key;
		logic rev_key;
		logic stop_key;
		logic pid_active;
	} contact_t;

	typedef struct packed {
		logic [15:0] freq;
		logic [15:0] ramp_time;
		logic ramp_to_base;
		logic run;
	} drive_cmd_t;
endpackage
`default_nettype wire

// *** verilog/nv_freq_store.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// One-word store; not reset so it survives a power-up reset
module nv_freq_store (
	input wire logic clk_in,
	input wire logic wr_en_in,
	input wire logic [15:0] wr_data_in,
	output logic [15:0] rd_data_out
);
	logic [15:0] cell_reg;

	always_ff @(posedge clk_in) begin
		if (wr_en_in) begin
			cell_reg <= wr_data_in;
		end
	end

	always_ff @(posedge clk_in) begin
		rd_data_out <= wr_en_in ? wr_data_in : cell_reg;
	end
endmodule
`default_nettype wire

// *** verilog/jog_remote_freq_setter.sv ***
// Behaviour
// - jog runs at inching frequency setting
// - one inching ramp time both directions
// - panel jog runs only while key held
// - pattern 1 ramps refer to base frequency
// - jog ignores second ramp selection
// - mode 4 panel keys start and stop
// - mode 3 disables panel jog
// - selection picks multi-speed or remote variants
// - speed contacts become increase, decrease, clear
// - remote amount adds to external command
// - mode 1 stores and restores set frequency
// - store when start input turns off
// - minute compare, write only on difference
// - limit to maximum frequency and main+max
// - second function off uses longer time
// - second function on uses second times
// - modes 1, 2 adjust while stopped
// - remote setting works in network mode
// - jog or PID disables remote setting
// - early power return resumes stored value
// - late power return resumes cleared value
// - lowest-ranked speed input wins
`timescale 1ns/1ps
`default_nettype none
module jog_remote_freq_setter #(
	parameter int unsigned MINUTE_CYCLES = remote_freq_pkg::MINUTE_CYC
) (
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire remote_freq_pkg::contact_t contact_in,
	input wire logic [15:0] external_freq_in,
	input wire logic [7:0] addr_in,
	input wire logic [31:0] wr_data_in,
	input wire logic wr_en_in,
	input wire logic rd_en_in,
	output logic [31:0] rd_data_out,
	output remote_freq_pkg::drive_cmd_t drive_out
);
	// ==========================================================
	// Helpers
	function automatic logic [15:0] longer(input logic [15:0] a,
		input logic [15:0] b);
		longer = (a > b) ? a : b;
	endfunction

	// ==========================================================
	// Registers
	logic [1:0] remote_function_selection_reg;
	logic [15:0] inching_frequency_reg;
	logic [15:0] inching_ramp_time_reg;
	logic [2:0] operation_mode_selection_reg;
	logic [1:0] ramp_pattern_selection_reg;
	logic [15:0] base_frequency_reg;
	logic [15:0] maximum_frequency_reg;
	logic [15:0] primary_accel_time_reg;
	logic [15:0] primary_decel_time_reg;
	logic [15:0] second_ramp_time_reg;
	logic [15:0] second_decel_time_reg;
	logic [15:0] speed_high_reg;
	logic [15:0] speed_mid_reg;
	logic [15:0] speed_low_reg;
	logic panel_jog_mode_reg;
	logic [15:0] set_freq_reg;
	logic [15:0] stored_freq;
	logic [1:0] boot_reg;
	logic panel_run_reg;
	logic start_was_reg;
	logic [1:0] updown_was_reg;
	logic [31:0] idle_cnt_reg;
	logic [47:0] acc_reg;
	remote_freq_pkg::contact_t meta_reg;
	remote_freq_pkg::contact_t pin_reg;

	// ==========================================================
	// Pin synchroniser, two stages
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			meta_reg <= '0;
			pin_reg <= '0;
		end else begin
			meta_reg <= contact_in;
			pin_reg <= meta_reg;
		end
	end

	// ==========================================================
	// Register writes
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			remote_function_selection_reg <=
				remote_freq_pkg::RST_REMOTE_SEL;
			inching_frequency_reg <= remote_freq_pkg::RST_INCH_FREQ;
			inching_ramp_time_reg <= remote_freq_pkg::RST_INCH_RAMP;
			operation_mode_selection_reg <= remote_freq_pkg::RST_OP_MODE;
			ramp_pattern_selection_reg <= remote_freq_pkg::RST_PATTERN;
			base_frequency_reg <= remote_freq_pkg::RST_BASE_FREQ;
			maximum_frequency_reg <= remote_freq_pkg::RST_MAX_FREQ;
			primary_accel_time_reg <= remote_freq_pkg::RST_PRIM_TIME;
			primary_decel_time_reg <= remote_freq_pkg::RST_PRIM_TIME;
			second_ramp_time_reg <= remote_freq_pkg::RST_SEC_RAMP;
			second_decel_time_reg <= remote_freq_pkg::RST_SEC_DEC;
			speed_high_reg <= remote_freq_pkg::RST_SPEED_HIGH;
			speed_mid_reg <= remote_freq_pkg::RST_SPEED_MID;
			speed_low_reg <= remote_freq_pkg::RST_SPEED_LOW;
			panel_jog_mode_reg <= 1'b0;
		end else if (wr_en_in) begin
			unique case (addr_in)
			remote_freq_pkg::ADDR_REMOTE_SEL:
				remote_function_selection_reg <= wr_data_in[1:0];
			remote_freq_pkg::ADDR_INCH_FREQ:
				inching_frequency_reg <= wr_data_in[15:0];
			remote_freq_pkg::ADDR_INCH_RAMP:
				inching_ramp_time_reg <= wr_data_in[15:0];
			remote_freq_pkg::ADDR_OP_MODE:
				operation_mode_selection_reg <= wr_data_in[2:0];
			remote_freq_pkg::ADDR_PATTERN:
				ramp_pattern_selection_reg <= wr_data_in[1:0];
			remote_freq_pkg::ADDR_BASE_FREQ:
				base_frequency_reg <= wr_data_in[15:0];
			remote_freq_pkg::ADDR_MAX_FREQ:
				maximum_frequency_reg <= wr_data_in[15:0];
			remote_freq_pkg::ADDR_PRIM_ACC:
				primary_accel_time_reg <= wr_data_in[15:0];
			remote_freq_pkg::ADDR_PRIM_DEC:
				primary_decel_time_reg <= wr_data_in[15:0];
			remote_freq_pkg::ADDR_SEC_RAMP:
				second_ramp_time_reg <= wr_data_in[15:0];
			remote_freq_pkg::ADDR_SEC_DEC:
				second_decel_time_reg <= wr_data_in[15:0];
			remote_freq_pkg::ADDR_SPEED_HIGH:
				speed_high_reg <= wr_data_in[15:0];
			remote_freq_pkg::ADDR_SPEED_MID:
				speed_mid_reg <= wr_data_in[15:0];
			remote_freq_pkg::ADDR_SPEED_LOW:
				speed_low_reg <= wr_data_in[15:0];
			remote_freq_pkg::ADDR_CONTROL:
				panel_jog_mode_reg <=
					wr_data_in[remote_freq_pkg::CTRL_PANEL_JOG_BIT];
			default: ;
			endcase
		end
	end

	// ==========================================================
	// Run and jog decisions
	logic start_any;
	logic panel_jog_run;
	logic ext_jog_run;
	logic jog_active;
	logic remote_en;
	logic run_now;

	assign start_any = pin_reg.fwd_start | pin_reg.rev_start;
	assign panel_jog_run = panel_jog_mode_reg & pin_reg.run_key &
		(operation_mode_selection_reg != remote_freq_pkg::OP_EXT_JOG_ONLY);
	assign ext_jog_run = pin_reg.jog_select & start_any;
	assign jog_active = panel_jog_run | ext_jog_run;
	// Network mode needs nothing extra; only jog or PID gate it
	assign remote_en = (remote_function_selection_reg != 2'h0) &
		~jog_active & ~pin_reg.pid_active;

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			panel_run_reg <= 1'b0;
		// Latch only in mode 4, else a stale start survives a mode change
		end else if (pin_reg.stop_key || operation_mode_selection_reg !=
			remote_freq_pkg::OP_PANEL_START) begin
			panel_run_reg <= 1'b0;
		// A held jog key must not latch, so release still stops
		end else if ((pin_reg.run_key & ~panel_jog_mode_reg) |
			pin_reg.fwd_key | pin_reg.rev_key) begin
			panel_run_reg <= 1'b1;
		end
	end

	assign run_now = jog_active | ((operation_mode_selection_reg ==
		remote_freq_pkg::OP_PANEL_START) ? panel_run_reg : start_any);

	// ==========================================================
	// Remote ramp timing
	logic [15:0] second_decel;
	logic [15:0] up_time;
	logic [15:0] down_time;
	logic [15:0] step_time;
	logic [47:0] step_limit;
	logic [47:0] acc_sum;
	logic step_now;
	logic go_up;
	logic go_down;

	assign second_decel = (second_decel_time_reg ==
		remote_freq_pkg::DECEL_FOLLOWS) ? second_ramp_time_reg :
		second_decel_time_reg;
	assign up_time = pin_reg.second_fn ? second_ramp_time_reg :
		longer(second_ramp_time_reg, primary_accel_time_reg);
	assign down_time = pin_reg.second_fn ? second_decel :
		longer(second_decel, primary_decel_time_reg);
	assign go_up = remote_en & pin_reg.increase & ~pin_reg.decrease &
		(start_any | (remote_function_selection_reg !=
		remote_freq_pkg::SEL_CLEAR_ON_STOP));
	assign go_down = remote_en & pin_reg.decrease & ~pin_reg.increase &
		(start_any | (remote_function_selection_reg !=
		remote_freq_pkg::SEL_CLEAR_ON_STOP));
	assign step_time = go_down ? down_time : up_time;
	assign step_limit = 48'(step_time) *
		48'(remote_freq_pkg::CYC_PER_TENTH);
	assign acc_sum = acc_reg + 48'(remote_freq_pkg::RAMP_REF_FREQ);
	assign step_now = (go_up | go_down) & (acc_sum >= step_limit);

	// Slope: reference frequency per ramp time, one 0.01 Hz step each
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			acc_reg <= '0;
		end else if (!(go_up | go_down) || step_limit == 48'h0) begin
			acc_reg <= '0;
		end else if (step_now) begin
			acc_reg <= acc_sum - step_limit;
		end else begin
			acc_reg <= acc_sum;
		end
	end

	// ==========================================================
	// Minute timer and storage
	logic updown_moved;
	logic minute_tick;
	logic start_fell;
	logic nv_wr;

	assign updown_moved = updown_was_reg !=
		{pin_reg.increase, pin_reg.decrease};
	assign minute_tick = ~updown_moved &
		(idle_cnt_reg == MINUTE_CYCLES - 1);
	assign start_fell = start_was_reg & ~start_any;

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			updown_was_reg <= 2'h0;
			idle_cnt_reg <= '0;
			start_was_reg <= 1'b0;
		end else begin
			updown_was_reg <= {pin_reg.increase, pin_reg.decrease};
			start_was_reg <= start_any;
			if (updown_moved || minute_tick) begin
				idle_cnt_reg <= '0;
			end else begin
				idle_cnt_reg <= idle_cnt_reg + 32'h1;
			end
		end
	end

	// Clear is not written until a minute tick sees the difference or the start input turns off
	assign nv_wr = (boot_reg == 2'h0) & (remote_function_selection_reg ==
		remote_freq_pkg::SEL_STORE) & (start_fell |
		(minute_tick & (set_freq_reg != stored_freq)));

	nv_freq_store store_u (
		.clk_in(clk_in),
		.wr_en_in(nv_wr),
		.wr_data_in(set_freq_reg),
		.rd_data_out(stored_freq)
	);

	// ==========================================================
	// Remotely set frequency
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			boot_reg <= 2'h3;
		end else begin
			boot_reg <= {1'b0, boot_reg[1]};
		end
	end

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			set_freq_reg <= 16'h0;
		end else if (boot_reg == 2'h1) begin
			set_freq_reg <= stored_freq;
		end else if (boot_reg != 2'h0) begin
			set_freq_reg <= set_freq_reg;
		end else if (remote_en && pin_reg.clear) begin
			set_freq_reg <= 16'h0;
		end else if (start_fell && remote_en &&
			remote_function_selection_reg ==
			remote_freq_pkg::SEL_CLEAR_ON_STOP) begin
			set_freq_reg <= 16'h0;
		end else if (set_freq_reg > maximum_frequency_reg) begin
			set_freq_reg <= maximum_frequency_reg;
		end else if (step_now && go_up &&
			set_freq_reg < maximum_frequency_reg) begin
			set_freq_reg <= set_freq_reg + 16'h1;
		end else if (step_now && go_down && set_freq_reg != 16'h0) begin
			set_freq_reg <= set_freq_reg - 16'h1;
		end
	end

	// ==========================================================
	// Frequency and ramp command
	logic [16:0] remote_sum;
	logic [15:0] freq_next;
	logic [15:0] ramp_next;

	// Saturates instead of wrapping at the 16-bit top
	assign remote_sum = {1'b0, external_freq_in} + {1'b0, set_freq_reg};

	always_comb begin
		if (jog_active) begin
			freq_next = inching_frequency_reg;
		end else if (remote_function_selection_reg == 2'h0) begin
			if (pin_reg.clear) begin
				freq_next = speed_low_reg;
			end else if (pin_reg.decrease) begin
				freq_next = speed_mid_reg;
			end else if (pin_reg.increase) begin
				freq_next = speed_high_reg;
			end else begin
				freq_next = external_freq_in;
			end
		end else if (remote_sum[16]) begin
			freq_next = 16'hffff;
		end else begin
			freq_next = remote_sum[15:0];
		end
	end

	always_comb begin
		if (jog_active) begin
			ramp_next = inching_ramp_time_reg;
		end else if (go_up | go_down) begin
			ramp_next = step_time;
		end else if (pin_reg.second_fn) begin
			ramp_next = second_ramp_time_reg;
		end else begin
			ramp_next = primary_accel_time_reg;
		end
	end

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			drive_out <= '0;
		end else begin
			drive_out.freq <= run_now ? freq_next : 16'h0;
			drive_out.ramp_time <= ramp_next;
			drive_out.ramp_to_base <= ramp_pattern_selection_reg ==
				remote_freq_pkg::PATTERN_S_A;
			drive_out.run <= run_now;
		end
	end

	// ==========================================================
	// Register reads, data one cycle after the strobe
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			rd_data_out <= 32'h0;
		end else if (rd_en_in) begin
			unique case (addr_in)
			remote_freq_pkg::ADDR_REMOTE_SEL:
				rd_data_out <= {30'h0, remote_function_selection_reg};
			remote_freq_pkg::ADDR_INCH_FREQ:
				rd_data_out <= {16'h0, inching_frequency_reg};
			remote_freq_pkg::ADDR_INCH_RAMP:
				rd_data_out <= {16'h0, inching_ramp_time_reg};
			remote_freq_pkg::ADDR_OP_MODE:
				rd_data_out <= {29'h0, operation_mode_selection_reg};
			remote_freq_pkg::ADDR_PATTERN:
				rd_data_out <= {30'h0, ramp_pattern_selection_reg};
			remote_freq_pkg::ADDR_BASE_FREQ:
				rd_data_out <= {16'h0, base_frequency_reg};
			remote_freq_pkg::ADDR_MAX_FREQ:
				rd_data_out <= {16'h0, maximum_frequency_reg};
			remote_freq_pkg::ADDR_PRIM_ACC:
				rd_data_out <= {16'h0, primary_accel_time_reg};
			remote_freq_pkg::ADDR_PRIM_DEC:
				rd_data_out <= {16'h0, primary_decel_time_reg};
			remote_freq_pkg::ADDR_SEC_RAMP:
				rd_data_out <= {16'h0, second_ramp_time_reg};
			remote_freq_pkg::ADDR_SEC_DEC:
				rd_data_out <= {16'h0, second_decel_time_reg};
			remote_freq_pkg::ADDR_SPEED_HIGH:
				rd_data_out <= {16'h0, speed_high_reg};
			remote_freq_pkg::ADDR_SPEED_MID:
				rd_data_out <= {16'h0, speed_mid_reg};
			remote_freq_pkg::ADDR_SPEED_LOW:
				rd_data_out <= {16'h0, speed_low_reg};
			remote_freq_pkg::ADDR_CONTROL:
				rd_data_out <= {31'h0, panel_jog_mode_reg};
			remote_freq_pkg::ADDR_SET_FREQ:
				rd_data_out <= {16'h0, set_freq_reg};
			remote_freq_pkg::ADDR_STORED:
				rd_data_out <= {16'h0, stored_freq};
			remote_freq_pkg::ADDR_STATUS:
				rd_data_out <= {29'h0, remote_en, run_now, jog_active};
			default:
				rd_data_out <= 32'h0;
			endcase
		end else begin
			rd_data_out <= 32'h0;
		end
	end

	// ==========================================================
	// Checks
	property p_jog_freq;
		@(posedge clk_in) disable iff (sys_rst_in)
		jog_active |=> drive_out.freq == $past(inching_frequency_reg);
	endproperty
	a_jog_freq: assert property (p_jog_freq)
		else $error("jog frequency not driven");

	property p_jog_ramp;
		@(posedge clk_in) disable iff (sys_rst_in)
		jog_active |=> drive_out.ramp_time == $past(inching_ramp_time_reg);
	endproperty
	a_jog_ramp: assert property (p_jog_ramp)
		else $error("jog ramp time not used");

	property p_panel_release;
		@(posedge clk_in) disable iff (sys_rst_in)
		$fell(pin_reg.run_key) && panel_jog_mode_reg && !start_any &&
			!ext_jog_run && operation_mode_selection_reg !=
			remote_freq_pkg::OP_PANEL_START |=> !drive_out.run;
	endproperty
	a_panel_release: assert property (p_panel_release)
		else $error("panel jog kept running after release");

	property p_base_ref;
		@(posedge clk_in) disable iff (sys_rst_in)
		ramp_pattern_selection_reg == remote_freq_pkg::PATTERN_S_A
			|=> drive_out.ramp_to_base;
	endproperty
	a_base_ref: assert property (p_base_ref)
		else $error("pattern 1 not referred to base");

	property p_mode3_jog;
		@(posedge clk_in) disable iff (sys_rst_in)
		operation_mode_selection_reg == remote_freq_pkg::OP_EXT_JOG_ONLY &&
			!pin_reg.jog_select |=> drive_out.run == $past(start_any);
	endproperty
	a_mode3_jog: assert property (p_mode3_jog)
		else $error("panel jog active in mode 3");

	property p_clear;
		@(posedge clk_in) disable iff (sys_rst_in)
		boot_reg == 2'h0 && remote_en && pin_reg.clear
			|=> set_freq_reg == 16'h0;
	endproperty
	a_clear: assert property (p_clear)
		else $error("clear input did not clear");

	property p_store_stop;
		@(posedge clk_in) disable iff (sys_rst_in)
		boot_reg == 2'h0 && start_fell && remote_function_selection_reg ==
			remote_freq_pkg::SEL_STORE |=> stored_freq == $past(set_freq_reg);
	endproperty
	a_store_stop: assert property (p_store_stop)
		else $error("frequency not stored at stop");

	property p_timer_restart;
		@(posedge clk_in) disable iff (sys_rst_in)
		updown_moved |=> idle_cnt_reg == 32'h0 ##1 idle_cnt_reg == 32'h1
			or updown_moved;
	endproperty
	a_timer_restart: assert property (p_timer_restart)
		else $error("minute timer did not restart");

	property p_remote_block;
		@(posedge clk_in) disable iff (sys_rst_in)
		boot_reg == 2'h0 && (jog_active || pin_reg.pid_active) &&
			set_freq_reg <= maximum_frequency_reg |=> $stable(set_freq_reg);
	endproperty
	a_remote_block: assert property (p_remote_block)
		else $error("remote setting moved during jog or PID");
endmodule
`default_nettype wire

// *** tb/contact_panel_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Contact switches and panel keys
module contact_panel_model (
	input wire logic clk_in,
	input wire remote_freq_pkg::contact_t cmd_in,
	output remote_freq_pkg::contact_t contact_out
);
	// Levels move on a rising edge, one cycle after the command
	always_ff @(posedge clk_in) begin
		contact_out <= cmd_in;
	end
endmodule
`default_nettype wire

// *** tb/jog_remote_freq_setter_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module jog_remote_freq_setter_bench;
	logic clk_in, sys_rst_in, wr_en_in, rd_en_in;
	logic [7:0] addr_in;
	logic [31:0] wr_data_in, rd_data_out;
	logic [15:0] external_freq_in;
	remote_freq_pkg::contact_t cmd, contact_in;
	remote_freq_pkg::drive_cmd_t drive_out;
	int n_fail, samples_checked;
	contact_panel_model u_pan (.clk_in(clk_in), .cmd_in(cmd),
		.contact_out(contact_in));
	// Short minute so storage timing fits the run
	jog_remote_freq_setter #(.MINUTE_CYCLES(200)) u_dut (.clk_in(clk_in),
		.sys_rst_in(sys_rst_in), .contact_in(contact_in),
		.external_freq_in(external_freq_in), .addr_in(addr_in),
		.wr_data_in(wr_data_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in),
		.rd_data_out(rd_data_out), .drive_out(drive_out));
	initial begin
		clk_in = 1'b0;
		forever #50 clk_in = ~clk_in;
	end
	// ==========================================================
	// Tasks
	task automatic conclude();
		$display("checks=%0d fails=%0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] t=%0t reg got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic chk_drv(input logic [15:0] g, input logic [15:0] e);
		samples_checked++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] t=%0t drv got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask
	task automatic pwr();
		@(posedge clk_in);
		sys_rst_in <= 1'b1;
		repeat (16) @(posedge clk_in);
		sys_rst_in <= 1'b0;
		cyc(3);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_in);
		addr_in <= a;
		wr_data_in <= d;
		wr_en_in <= 1'b1;
		@(posedge clk_in);
		wr_en_in <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk_in);
		addr_in <= a;
		rd_en_in <= 1'b1;
		@(posedge clk_in);
		rd_en_in <= 1'b0;
		#1;
		chk_reg(rd_data_out, e);
	endtask
	// Bits: inc dec clr fwd rev sec jog run fkey rkey stop pid
	task automatic pins(input logic [11:0] v);
		@(posedge clk_in);
		cmd <= v;
		cyc(6);
	endtask
	// Bounded wait; a hang ends the run as a mismatch
	task automatic wait_freq(input logic [15:0] e);
		int i;
		for (i = 0; i < 3000 && drive_out.freq !== e; i++) begin
			cyc(1);
		end
		chk_drv(drive_out.freq, e);
		if (i == 3000) conclude();
	endtask
	// ==========================================================
	// Sequence
	initial begin
		sys_rst_in = 1'b1;
		{wr_en_in, rd_en_in, addr_in, wr_data_in} = '0;
		external_freq_in = 16'h0100;
		cmd = '0;
		n_fail = 0;
		samples_checked = 0;
		pwr();
		rd(8'h00, 32'h0);
		rd(8'h04, 32'h01f4);
		rd(8'h08, 32'h0005);
		rd(8'h28, 32'h270f);
		rd(8'h48, 32'h0);
		pins(12'h160);
		chk_drv(drive_out.freq, 16'h01f4);
		chk_drv(drive_out.ramp_time, 16'h0005);
		wr(8'h04, 32'h03e8);
		wr(8'h10, 32'h1);
		cyc(6);
		chk_drv(drive_out.freq, 16'h03e8);
		chk_drv({15'h0, drive_out.ramp_to_base}, 16'h1);
		pins(12'h000);
		wr(8'h38, 32'h1);
		pins(12'h010);
		chk_drv({15'h0, drive_out.run}, 16'h1);
		pins(12'h000);
		chk_drv({15'h0, drive_out.run}, 16'h0);
		wr(8'h0c, 32'h3);
		pins(12'h010);
		chk_drv({15'h0, drive_out.run}, 16'h0);
		wr(8'h0c, 32'h4);
		pins(12'h000);
		chk_drv({15'h0, drive_out.run}, 16'h0);
		pins(12'h008);
		pins(12'h000);
		chk_drv({15'h0, drive_out.run}, 16'h1);
		pins(12'h002);
		chk_drv({15'h0, drive_out.run}, 16'h0);
		wr(8'h38, 32'h0);
		wr(8'h0c, 32'h0);
		wr(8'h00, 32'h2);
		wr(8'h18, 32'h3);
		wr(8'h24, 32'h1);
		pins(12'h200);
		rd(8'h3c, 32'h0);
		pins(12'h940);
		chk_drv(drive_out.ramp_time, 16'h0001);
		wait_freq(16'h0103);
		rd(8'h3c, 32'h3);
		pins(12'h500);
		chk_drv(drive_out.ramp_time, 16'h0032);
		pins(12'h200);
		pins(12'h840);
		cyc(1000);
		rd(8'h3c, 32'h3);
		pins(12'h201);
		rd(8'h3c, 32'h3);
		wr(8'h00, 32'h3);
		pins(12'h100);
		pins(12'h000);
		rd(8'h3c, 32'h0);
		pins(12'h840);
		cyc(1000);
		rd(8'h3c, 32'h0);
		wr(8'h00, 32'h1);
		pins(12'h940);
		wait_freq(16'h0103);
		pins(12'h140);
		pins(12'h000);
		rd(8'h40, 32'h3);
		pwr();
		rd(8'h3c, 32'h3);
		wr(8'h00, 32'h1);
		pins(12'h200);
		pins(12'h000);
		pwr();
		rd(8'h3c, 32'h3);
		wr(8'h00, 32'h1);
		pins(12'h200);
		pins(12'h000);
		cyc(500);
		rd(8'h40, 32'h0);
		pwr();
		rd(8'h3c, 32'h0);
		pins(12'hd00);
		chk_drv(drive_out.freq, 16'h0bb8);
		conclude();
	end
endmodule
`default_nettype wire
